// File: bslp_top.sv
/*
 * boot section lock protection: lock byte storage, boot size fuse use,
 * pointer decode, permission checks for self-program writes and program
 * memory reads, external programming gates, interrupt masking and the
 * readable area busy flag.
 * assumes the core presents one command or read request per cycle, all
 * on core_clk, and that the flash timing engine reports completion.
 */
//
// Functional notes
// - boot size fuses choose boot start, size
// - only upper 32 pages readable while programming
// - 16-bit counter, 128-word pages, word PC[6:0]
// - page number from pointer bits 16..8
// - word position from pointer bits 7..1
// - pointer bit 0 is byte select only
// - pointer bit 16 from extended page register
// - lock bits return to 1 by chip erase
// - lock byte layout, bits 7..6 unused
// - memory lock mode 1 no restriction
// - mode 2 blocks external programming, fuses
// - mode 3 also blocks external verification
// - app mode 1 allows writes and reads
// - app modes 2,3 block app writes
// - app mode 3 blocks boot reads of app
// - app mode 4 blocks reads, allows writes
// - interrupts off in app if vectors boot, app modes 3,4 only
// - busy flag holds until re-enable command
// - boot pair acts alike for boot section
// - boot size fuses at high fuse bits 2,1
`timescale 1ns/100ps
`include "bslp_map.svh"
module bslp_top
(
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire logic [7:0]            fuseHigh,
    input  wire logic [15:0]           programCounter,
    input  wire logic [15:0]           zPointer,
    input  wire logic [7:0]            extended_page_reg,
    input  wire logic                  spmReq,
    input  wire bslp_pkg::bslp_cmd_e   spmCmd,
    input  wire logic                  eeprom_write_active,
    input  wire logic                  spmDone,
    input  wire logic                  lpmReq,
    input  wire logic                  lockWriteReq,
    input  wire logic [7:0]            lockWriteData,
    input  wire logic                  chipEraseReq,
    input  wire logic                  vectorsInBoot,
    input  wire logic                  extProgReq,
    input  wire logic                  extVerifyReq,
    input  wire logic                  extFuseReq,
    output logic [7:0]                 flash_lock_byte,
    output logic                       spmAllow,
    output logic                       spmStart,
    output logic                       lpmAllow,
    output logic                       lpmByteSel,
    output logic [8:0]                 page_select_field,
    output logic [6:0]                 word_select_field,
    output logic                       readable_area_busy,
    output logic                       readable_while_write_area,
    output logic                       blocked_during_write_area,
    output logic                       intMask,
    output logic                       extProgAllow,
    output logic                       extVerifyAllow,
    output logic                       extFuseAllow,
    output logic [15:0]                bootStartAddr,
    output logic [5:0]                 bootPageCount
);

    logic                   rstSync1_ff;
    logic                   rstSync2_ff;
    logic                   rstN;

    logic [7:0]             lock_ff;
    logic [7:0]             nxt_lock;
    logic [1:0]             bootSize_ff;
    logic [1:0]             nxt_bootSize;
    logic                   fuseLatched_ff;
    logic                   nxt_fuseLatched;

    bslp_pkg::bslp_state_e  state_ff;
    bslp_pkg::bslp_state_e  nxt_state;
    logic                   spmAllow_ff;
    logic                   nxt_spmAllow;
    logic                   lpmAllow_ff;
    logic                   nxt_lpmAllow;

    logic [16:0]            fullPtr;
    logic [15:0]            targetWord;

    bslp_pkg::bslp_mode_e   appMode;
    bslp_pkg::bslp_mode_e   bootMode;
    bslp_pkg::bslp_mode_e   memMode;

    logic                   pcInBoot;
    logic                   tgtInBoot;
    logic                   tgtInBlocked;

    logic                   pageCmd;
    logic                   writeOk;
    logic                   readOk;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
        end
        else
        begin
            rstSync1_ff <= 1'b1;
            rstSync2_ff <= rstSync1_ff;
        end
    end
    assign rstN = rstSync2_ff;

    // full pointer with extended bit
    assign fullPtr    = {extended_page_reg[0], zPointer};
    assign targetWord = fullPtr[`BSLP_PAGE_MSB:`BSLP_WORD_LSB];

    // pointer field decode
    assign page_select_field = fullPtr[`BSLP_PAGE_MSB:`BSLP_PAGE_LSB];
    assign word_select_field = fullPtr[`BSLP_WORD_MSB:`BSLP_WORD_LSB];
    assign lpmByteSel        = fullPtr[`BSLP_BYTE_SEL];

    // lock pair modes
    bslp_mode_decode u_app_mode
    (
        .lockPair ({lock_ff[`BSLP_LOCK_APP_HI], lock_ff[`BSLP_LOCK_APP_LO]}),
        .mode     (appMode)
    );
    bslp_mode_decode u_boot_mode
    (
        .lockPair ({lock_ff[`BSLP_LOCK_BOOT_HI], lock_ff[`BSLP_LOCK_BOOT_LO]}),
        .mode     (bootMode)
    );
    bslp_mode_decode u_mem_mode
    (
        .lockPair ({lock_ff[`BSLP_LOCK_MEM_HI], lock_ff[`BSLP_LOCK_MEM_LO]}),
        .mode     (memMode)
    );

    // section of the executing instruction
    bslp_section_map u_pc_map
    (
        .bootSize  (bootSize_ff),
        .wordAddr  (programCounter),
        .bootStart (bootStartAddr),
        .bootPages (bootPageCount),
        .inBoot    (pcInBoot),
        .inBlocked ()
    );

    // section of the access target
    bslp_section_map u_tgt_map
    (
        .bootSize  (bootSize_ff),
        .wordAddr  (targetWord),
        .bootStart (),
        .bootPages (),
        .inBoot    (tgtInBoot),
        .inBlocked (tgtInBlocked)
    );

    // write permission per target section
    always_comb
    begin
        if (tgtInBoot)
            writeOk = (bootMode == bslp_pkg::BSLP_MODE_1) ||
                      (bootMode == bslp_pkg::BSLP_MODE_4);
        else
            writeOk = (appMode == bslp_pkg::BSLP_MODE_1) ||
                      (appMode == bslp_pkg::BSLP_MODE_4);
    end

    // read permission across sections, re-judged every access
    always_comb
    begin
        readOk = 1'b1;
        if (pcInBoot && !tgtInBoot)
            readOk = !((appMode == bslp_pkg::BSLP_MODE_3) ||
                       (appMode == bslp_pkg::BSLP_MODE_4));
        else if (!pcInBoot && tgtInBoot)
            readOk = !((bootMode == bslp_pkg::BSLP_MODE_3) ||
                       (bootMode == bslp_pkg::BSLP_MODE_4));
        if (readable_area_busy && !tgtInBlocked)
            readOk = 1'b0;
    end

    // area flags
    assign readable_while_write_area = !tgtInBlocked;
    assign blocked_during_write_area = tgtInBlocked;

    // interrupt masking while in the other section
    always_comb
    begin
        intMask = 1'b0;
        if (vectorsInBoot && !pcInBoot &&
            ((appMode == bslp_pkg::BSLP_MODE_3) || (appMode == bslp_pkg::BSLP_MODE_4)))
            intMask = 1'b1;
        if (!vectorsInBoot && pcInBoot &&
            ((bootMode == bslp_pkg::BSLP_MODE_3) || (bootMode == bslp_pkg::BSLP_MODE_4)))
            intMask = 1'b1;
    end

    // external programming gates
    assign extProgAllow   = extProgReq && (memMode == bslp_pkg::BSLP_MODE_1);
    assign extVerifyAllow = extVerifyReq && (memMode != bslp_pkg::BSLP_MODE_3);
    assign extFuseAllow   = extFuseReq && (memMode == bslp_pkg::BSLP_MODE_1);

    // command acceptance
    assign pageCmd  = (spmCmd == bslp_pkg::BSLP_CMD_ERASE) ||
                      (spmCmd == bslp_pkg::BSLP_CMD_WRITE);
    assign spmStart = spmReq && writeOk && !eeprom_write_active &&
                      (state_ff != bslp_pkg::BSLP_ST_PROG);

    // lock byte, fuse latch and permission registers
    always_comb
    begin
        nxt_lock        = lock_ff;
        nxt_bootSize    = bootSize_ff;
        nxt_fuseLatched = 1'b1;
        if (!fuseLatched_ff)
            nxt_bootSize = {fuseHigh[`BSLP_FUSE_BOOTSZ_HI],
                            fuseHigh[`BSLP_FUSE_BOOTSZ_LO]};
        if (chipEraseReq)
            nxt_lock = `BSLP_LOCK_RESET;
        else if (lockWriteReq)
            nxt_lock = lock_ff & (lockWriteData | ~`BSLP_LOCK_USED_MASK);
        nxt_spmAllow = spmReq && writeOk;
        nxt_lpmAllow = lpmReq && readOk;
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            lock_ff        <= `BSLP_LOCK_RESET;
            bootSize_ff    <= `BSLP_BOOTSZ_RESET;
            fuseLatched_ff <= 1'b0;
            spmAllow_ff    <= 1'b0;
            lpmAllow_ff    <= 1'b0;
        end
        else
        begin
            lock_ff        <= nxt_lock;
            bootSize_ff    <= nxt_bootSize;
            fuseLatched_ff <= nxt_fuseLatched;
            spmAllow_ff    <= nxt_spmAllow;
            lpmAllow_ff    <= nxt_lpmAllow;
        end
    end

    assign flash_lock_byte = lock_ff;
    assign spmAllow        = spmAllow_ff;
    assign lpmAllow        = lpmAllow_ff;

    // busy flag sequencing
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            bslp_pkg::BSLP_ST_IDLE:
            begin
                if (spmStart && pageCmd)
                    nxt_state = bslp_pkg::BSLP_ST_PROG;
            end
            bslp_pkg::BSLP_ST_PROG:
            begin
                if (spmDone)
                    nxt_state = bslp_pkg::BSLP_ST_DONE;
            end
            bslp_pkg::BSLP_ST_DONE:
            begin
                if (spmStart && pageCmd)
                    nxt_state = bslp_pkg::BSLP_ST_PROG;
                else if (spmReq && (spmCmd == bslp_pkg::BSLP_CMD_RWWEN))
                    nxt_state = bslp_pkg::BSLP_ST_IDLE;
            end
            default:
                nxt_state = bslp_pkg::BSLP_ST_IDLE;
        endcase
    end

    // busy state register
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            state_ff <= bslp_pkg::BSLP_ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    assign readable_area_busy = (state_ff != bslp_pkg::BSLP_ST_IDLE);

endmodule

// File: bslp_map.svh
/*
 * register layout, field positions, reset values and flash geometry
 * for the boot section lock protection block.
 * assumes it is included by bare name wherever these constants are used.
 */
`ifndef BSLP_MAP_SVH
`define BSLP_MAP_SVH

// lock byte fields
`define BSLP_LOCK_RESET      8'hff
`define BSLP_LOCK_USED_MASK  8'h3f
`define BSLP_LOCK_MEM_LO     0
`define BSLP_LOCK_MEM_HI     1
`define BSLP_LOCK_APP_LO     2
`define BSLP_LOCK_APP_HI     3
`define BSLP_LOCK_BOOT_LO    4
`define BSLP_LOCK_BOOT_HI    5

// high fuse byte fields
`define BSLP_FUSE_BOOTSZ_LO  1
`define BSLP_FUSE_BOOTSZ_HI  2
`define BSLP_BOOTSZ_RESET    2'h0

// boot start word addresses per size code
`define BSLP_BOOT_START_512  16'hfe00
`define BSLP_BOOT_START_1K   16'hfc00
`define BSLP_BOOT_START_2K   16'hf800
`define BSLP_BOOT_START_4K   16'hf000
`define BSLP_BOOT_PAGES_512  6'h04
`define BSLP_BOOT_PAGES_1K   6'h08
`define BSLP_BOOT_PAGES_2K   6'h10
`define BSLP_BOOT_PAGES_4K   6'h20

// fixed read-while-write limit
`define BSLP_BLOCKED_DURING_WRITE_AREA_START      16'hf000
`define BSLP_RWW_PAGES       9'h1e0
`define BSLP_BLOCKED_DURING_WRITE_AREA_PAGES      9'h020

// pointer fields
`define BSLP_PAGE_MSB        16
`define BSLP_PAGE_LSB        8
`define BSLP_WORD_MSB        7
`define BSLP_WORD_LSB        1
`define BSLP_BYTE_SEL        0

`endif

// File: bslp_pkg.sv
/*
 * types for the boot section lock protection block.
 * assumes bslp_map.svh supplies the numeric constants.
 */
package bslp_pkg;

    // lock pair modes, binary codes
    typedef enum logic [1:0] {
        BSLP_MODE_1 = 2'b00,
        BSLP_MODE_2 = 2'b01,
        BSLP_MODE_3 = 2'b10,
        BSLP_MODE_4 = 2'b11
    } bslp_mode_e;

    // self-program command type
    typedef enum logic [1:0] {
        BSLP_CMD_FILL  = 2'b00,
        BSLP_CMD_ERASE = 2'b01,
        BSLP_CMD_WRITE = 2'b10,
        BSLP_CMD_RWWEN = 2'b11
    } bslp_cmd_e;

    // busy flag states
    typedef enum logic [1:0] {
        BSLP_ST_IDLE  = 2'b00,
        BSLP_ST_PROG  = 2'b01,
        BSLP_ST_DONE  = 2'b10
    } bslp_state_e;

endpackage

// File: bslp_mode_decode.sv
/*
 * decodes one two-bit lock pair into its protection mode.
 * assumes bits are 1 when unprogrammed.
 */
`timescale 1ns/100ps
module bslp_mode_decode
(
    input  wire logic [1:0]         lockPair,
    output bslp_pkg::bslp_mode_e    mode
);

    // hi/lo pair to mode
    always_comb
    begin
        case (lockPair)
            2'b11:   mode = bslp_pkg::BSLP_MODE_1;
            2'b10:   mode = bslp_pkg::BSLP_MODE_2;
            2'b00:   mode = bslp_pkg::BSLP_MODE_3;
            default: mode = bslp_pkg::BSLP_MODE_4;
        endcase
    end

endmodule

// File: bslp_section_map.sv
/*
 * maps boot size fuses to boot start and size, and classifies an address.
 * assumes addresses are 16-bit word addresses.
 */
`timescale 1ns/100ps
`include "bslp_map.svh"
module bslp_section_map
(
    input  wire logic [1:0]   bootSize,
    input  wire logic [15:0]  wordAddr,
    output logic [15:0]       bootStart,
    output logic [5:0]        bootPages,
    output logic              inBoot,
    output logic              inBlocked
);

    // size code to boundary, boot ends at top of flash
    always_comb
    begin
        case (bootSize)
            2'b11:
            begin
                bootStart = `BSLP_BOOT_START_512;
                bootPages = `BSLP_BOOT_PAGES_512;
            end
            2'b10:
            begin
                bootStart = `BSLP_BOOT_START_1K;
                bootPages = `BSLP_BOOT_PAGES_1K;
            end
            2'b01:
            begin
                bootStart = `BSLP_BOOT_START_2K;
                bootPages = `BSLP_BOOT_PAGES_2K;
            end
            default:
            begin
                bootStart = `BSLP_BOOT_START_4K;
                bootPages = `BSLP_BOOT_PAGES_4K;
            end
        endcase
    end

    // address classification
    assign inBoot    = (wordAddr >= bootStart);
    assign inBlocked = (wordAddr >= `BSLP_BLOCKED_DURING_WRITE_AREA_START);

endmodule

// File: bslp_core_model.sv
/*
 * processor core model: issues self-program commands and program memory
 * reads, and stands in for the flash timing engine's completion pulse.
 * assumes requests launch at the falling edge of core_clk.
 */
`timescale 1ns/100ps
module bslp_core_model
(
    input  wire logic           core_clk,
    input  wire logic           spmStart,
    output logic [15:0]         programCounter,
    output logic [15:0]         zPointer,
    output logic [7:0]          extended_page_reg,
    output logic                spmReq,
    output bslp_pkg::bslp_cmd_e spmCmd,
    output logic                lpmReq,
    output logic                spmDone
);
    // idle core at time zero
    initial
    begin
        programCounter = 16'h0000;
        zPointer = 16'h0000;
        extended_page_reg = 8'h00;
        spmReq = 1'b0;
        spmCmd = bslp_pkg::BSLP_CMD_FILL;
        lpmReq = 1'b0;
        spmDone = 1'b0;
    end

    // place executing address and pointer, bit 16 in the page register
    task automatic place(input logic [15:0] pc, input logic [16:0] z);
        @(negedge core_clk);
        programCounter = pc;
        extended_page_reg = {7'h00, z[16]};
        zPointer = z[15:0];
    endtask

    // one command; started page ops wait for the engine
    task automatic spm(input bslp_pkg::bslp_cmd_e cmd, input logic [15:0] pc,
                       input logic [16:0] z, input int dly, output logic started);
        place(pc, z);
        zPointer[0] = 1'b0;
        if (cmd == bslp_pkg::BSLP_CMD_WRITE)
            zPointer[7:1] = 7'h00;
        spmCmd = cmd;
        spmReq = 1'b1;
        #1 started = spmStart;
        @(negedge core_clk);
        spmReq = 1'b0;
        if (started && cmd inside {bslp_pkg::BSLP_CMD_ERASE, bslp_pkg::BSLP_CMD_WRITE})
        begin
            repeat (dly) @(negedge core_clk);
            spmDone = 1'b1;
            @(negedge core_clk);
            spmDone = 1'b0;
        end
    endtask

    // one program memory read, held across one rising edge
    task automatic lpm(input logic [15:0] pc, input logic [16:0] z);
        place(pc, z);
        lpmReq = 1'b1;
        @(negedge core_clk);
        lpmReq = 1'b0;
    endtask
endmodule

// File: bslp_top_chk.sv
/*
 * port assertions for the boot section lock protection block.
 * assumes a single core_clk domain and binding onto bslp_top.
 */
`timescale 1ns/100ps
module bslp_top_chk
(
    input wire logic                core_clk,
    input wire logic                reset_n,
    input wire logic [15:0]         programCounter,
    input wire logic [15:0]         zPointer,
    input wire logic [7:0]          extended_page_reg,
    input wire bslp_pkg::bslp_cmd_e spmCmd,
    input wire logic                spmReq,
    input wire logic                chipEraseReq,
    input wire logic                vectorsInBoot,
    input wire logic                extProgReq,
    input wire logic                extVerifyReq,
    input wire logic                extFuseReq,
    input wire logic [7:0]          flash_lock_byte,
    input wire logic                spmStart,
    input wire logic                lpmAllow,
    input wire logic                lpmByteSel,
    input wire logic [8:0]          page_select_field,
    input wire logic [6:0]          word_select_field,
    input wire logic                readable_area_busy,
    input wire logic                readable_while_write_area,
    input wire logic                blocked_during_write_area,
    input wire logic                intMask,
    input wire logic                extProgAllow,
    input wire logic                extVerifyAllow,
    input wire logic                extFuseAllow,
    input wire logic [15:0]         bootStartAddr
);
    logic [15:0] tgtWord;
    logic        tgtBoot;
    logic        pcBoot;
    logic        pageOp;

    // target word, sections of target and executing code
    assign tgtWord = {extended_page_reg[0], zPointer[15:1]};
    assign tgtBoot = tgtWord >= bootStartAddr;
    assign pcBoot = programCounter >= bootStartAddr;
    assign pageOp = spmCmd inside {bslp_pkg::BSLP_CMD_ERASE, bslp_pkg::BSLP_CMD_WRITE};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_PTR_FIELDS:
    assert property (page_select_field == {extended_page_reg[0], zPointer[15:8]}
        && word_select_field == zPointer[7:1] && lpmByteSel == zPointer[0])
        else $error("pointer fields wrong");
    AST_AREA_SPLIT:
    assert property (blocked_during_write_area == (tgtWord >= 16'hf000)
        && readable_while_write_area == (tgtWord < 16'hf000)) else $error("area split wrong");
    AST_LOCK_CLEARS:
    assert property (!$past(chipEraseReq) |-> (flash_lock_byte & ~$past(flash_lock_byte)) == 8'h00)
        else $error("lock bit set without erase");
    AST_LOCK_UNUSED:
    assert property (flash_lock_byte[7:6] == 2'b11) else $error("unused lock bits low");
    AST_SPM_APP:
    assert property (spmStart && pageOp && !tgtBoot |-> flash_lock_byte[2])
        else $error("app write passed lock");
    AST_SPM_BOOT:
    assert property (spmStart && pageOp && tgtBoot |-> flash_lock_byte[4])
        else $error("boot write passed lock");
    AST_LPM_APP:
    assert property (lpmAllow |-> !($past(pcBoot) && !$past(tgtBoot) && !$past(flash_lock_byte[3])))
        else $error("app read passed lock");
    AST_LPM_BOOT:
    assert property (lpmAllow |-> !(!$past(pcBoot) && $past(tgtBoot) && !$past(flash_lock_byte[5])))
        else $error("boot read passed lock");
    AST_INT_MASK:
    assert property (intMask == ((vectorsInBoot && !pcBoot && !flash_lock_byte[3])
        || (!vectorsInBoot && pcBoot && !flash_lock_byte[5]))) else $error("interrupt mask wrong");
    AST_EXT_GATES:
    assert property ((extProgAllow |-> extProgReq && flash_lock_byte[1:0] == 2'b11)
        and (extFuseAllow |-> extFuseReq && flash_lock_byte[1:0] == 2'b11)
        and (extVerifyAllow |-> extVerifyReq && flash_lock_byte[1:0] != 2'b00))
        else $error("external gate open when locked");
    AST_BUSY_RISE:
    assert property ($rose(readable_area_busy) |-> $past(spmStart && pageOp))
        else $error("busy rose without page op");
    AST_BUSY_FALL:
    assert property ($fell(readable_area_busy) |-> $past(spmReq)
        && $past(spmCmd) == bslp_pkg::BSLP_CMD_RWWEN) else $error("busy fell without re-enable");
endmodule

bind bslp_top bslp_top_chk u_chk
(
    .core_clk(core_clk), .reset_n(reset_n), .programCounter(programCounter),
    .zPointer(zPointer), .extended_page_reg(extended_page_reg), .spmCmd(spmCmd),
    .spmReq(spmReq), .chipEraseReq(chipEraseReq), .vectorsInBoot(vectorsInBoot),
    .extProgReq(extProgReq), .extVerifyReq(extVerifyReq), .extFuseReq(extFuseReq),
    .flash_lock_byte(flash_lock_byte), .spmStart(spmStart), .lpmAllow(lpmAllow),
    .lpmByteSel(lpmByteSel), .page_select_field(page_select_field),
    .word_select_field(word_select_field), .readable_area_busy(readable_area_busy),
    .readable_while_write_area(readable_while_write_area),
    .blocked_during_write_area(blocked_during_write_area), .intMask(intMask),
    .extProgAllow(extProgAllow), .extVerifyAllow(extVerifyAllow),
    .extFuseAllow(extFuseAllow), .bootStartAddr(bootStartAddr)
);

// File: bslp_top_bench.sv
/*
 * self-checking bench for the boot section lock protection block.
 * assumes bslp_core_model drives the core side and the checker is bound.
 */
`timescale 1ns/100ps
module bslp_top_bench;
    localparam bslp_pkg::bslp_cmd_e cmdEr = bslp_pkg::BSLP_CMD_ERASE;
    localparam bslp_pkg::bslp_cmd_e cmdWr = bslp_pkg::BSLP_CMD_WRITE;
    localparam bslp_pkg::bslp_cmd_e cmdRe = bslp_pkg::BSLP_CMD_RWWEN;
    logic                core_clk = 1'b0;
    logic                reset_n = 1'b0;
    logic [7:0]          fuseHigh = 8'hf9;
    logic                lockWriteReq = 1'b0;
    logic [7:0]          lockWriteData = 8'hff;
    logic                chipEraseReq = 1'b0;
    logic                vectorsInBoot = 1'b0;
    logic                extProgReq = 1'b0;
    logic                extVerifyReq = 1'b0;
    logic                extFuseReq = 1'b0, eeBusy = 1'b0;
    logic [15:0]         programCounter, zPointer, bootStartAddr;
    logic [7:0]          extended_page_reg, flash_lock_byte;
    logic                spmReq, lpmReq, spmDone, spmStart, lpmAllow, readable_area_busy;
    logic                intMask, extProgAllow, extVerifyAllow, extFuseAllow, ok, spmAllow;
    logic [5:0]          bootPageCount;
    bslp_pkg::bslp_cmd_e spmCmd;
    logic [1:0]          pairs [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
    logic [15:0]         starts [4] = '{16'hf000, 16'hf800, 16'hfc00, 16'hfe00};
    int                  fails = 0;
    int                  checkCount = 0;

    always #2 core_clk = ~core_clk;

    bslp_core_model u_core (.core_clk(core_clk), .spmStart(spmStart),
        .programCounter(programCounter), .zPointer(zPointer),
        .extended_page_reg(extended_page_reg), .spmReq(spmReq), .spmCmd(spmCmd),
        .lpmReq(lpmReq), .spmDone(spmDone));

    bslp_top u_dut (.core_clk(core_clk), .reset_n(reset_n), .fuseHigh(fuseHigh),
        .programCounter(programCounter), .zPointer(zPointer),
        .extended_page_reg(extended_page_reg), .spmReq(spmReq), .spmCmd(spmCmd),
        .eeprom_write_active(eeBusy), .spmDone(spmDone), .lpmReq(lpmReq),
        .lockWriteReq(lockWriteReq), .lockWriteData(lockWriteData),
        .chipEraseReq(chipEraseReq), .vectorsInBoot(vectorsInBoot),
        .extProgReq(extProgReq), .extVerifyReq(extVerifyReq), .extFuseReq(extFuseReq),
        .flash_lock_byte(flash_lock_byte), .spmAllow(spmAllow), .spmStart(spmStart),
        .lpmAllow(lpmAllow), .lpmByteSel(), .page_select_field(), .word_select_field(),
        .readable_area_busy(readable_area_busy), .readable_while_write_area(),
        .blocked_during_write_area(), .intMask(intMask), .extProgAllow(extProgAllow),
        .extVerifyAllow(extVerifyAllow), .extFuseAllow(extFuseAllow),
        .bootStartAddr(bootStartAddr), .bootPageCount(bootPageCount));

    // compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic endOfTest();
        if (fails == 0 && checkCount > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // reset with boot size code in fuse bits 2..1
    task automatic doReset(input logic [1:0] size);
        @(negedge core_clk);
        reset_n = 1'b0;
        fuseHigh = {5'h1f, size, 1'b1};
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge core_clk);
    endtask

    // one lock byte write or chip erase pulse
    task automatic lockOp(input logic erase, input logic [7:0] data);
        @(negedge core_clk);
        chipEraseReq = erase;
        lockWriteReq = !erase;
        lockWriteData = data;
        @(negedge core_clk);
        chipEraseReq = 1'b0;
        lockWriteReq = 1'b0;
    endtask

    // main sequence
    initial
    begin
        logic [1:0]  pair;
        for (int i = 3; i >= 0; i--)
        begin
            doReset(2'(i));
            check("bootStart", bootStartAddr, starts[i]);
            check("bootPages", 16'(bootPageCount), 16'((17'h10000 - starts[i]) >> 7));
            check("lockReset", 16'(flash_lock_byte), 16'h00ff);
        end
        u_core.spm(cmdWr, 16'hf000, 17'h00200, 20, ok);
        check("spmWrite", 16'(ok), 16'h0001);
        check("busyAfterDone", 16'(readable_area_busy), 16'h0001);
        u_core.lpm(16'hf000, 17'h00200);
        check("lpmRwwBusy", 16'(lpmAllow), 16'h0000);
        u_core.lpm(16'hf000, 17'h1e400);
        check("lpmNrwwBusy", 16'(lpmAllow), 16'h0001);
        u_core.spm(cmdRe, 16'hf000, 17'h00000, 1, ok);
        check("busyCleared", 16'(readable_area_busy), 16'h0000);
        u_core.lpm(16'hf000, 17'h00200);
        check("lpmRwwFree", 16'(lpmAllow), 16'h0001);
        eeBusy = 1'b1;
        u_core.spm(cmdEr, 16'hf000, 17'h00200, 1, ok);
        check("spmEe", 16'(ok), 16'h0000);
        eeBusy = 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            pair = pairs[m];
            lockOp(1'b1, 8'hff);
            lockOp(1'b0, {2'b11, pair, pair, 2'b11});
            check("lockByte", 16'(flash_lock_byte), 16'({2'b11, pair, pair, 2'b11}));
            vectorsInBoot = 1'b1;
            u_core.lpm(16'hf800, 17'h00200);
            check("lpmBootToApp", 16'(lpmAllow), 16'(pair[1]));
            u_core.lpm(16'h0100, 17'h1f000);
            check("lpmAppToBoot", 16'(lpmAllow), 16'(pair[1]));
            check("intMaskApp", 16'(intMask), 16'(!pair[1]));
            vectorsInBoot = 1'b0;
            u_core.lpm(16'hf800, 17'h1f000);
            check("lpmSame", 16'(lpmAllow), 16'h0001);
            check("intMaskBoot", 16'(intMask), 16'(!pair[1]));
            u_core.spm(cmdEr, 16'hf800, 17'h00200, 1, ok);
            check("spmApp", 16'(ok), 16'(pair[0]));
            u_core.spm(cmdRe, 16'hf800, 17'h00000, 1, ok);
            check("spmAllow", 16'(spmAllow), 16'(pair[0]));
            u_core.spm(cmdWr, 16'h0100, 17'h1f000, 3, ok);
            check("spmBoot", 16'(ok), 16'(pair[0]));
            u_core.spm(cmdRe, 16'h0100, 17'h00000, 1, ok);
        end
        extProgReq = 1'b1;
        extVerifyReq = 1'b1;
        extFuseReq = 1'b1;
        for (int m = 0; m < 3; m++)
        begin
            lockOp(1'b1, 8'hff);
            lockOp(1'b0, {6'h3f, pairs[m]});
            check("extProg", 16'(extProgAllow), 16'(pairs[m] == 2'b11));
            check("extFuse", 16'(extFuseAllow), 16'(pairs[m] == 2'b11));
            check("extVerify", 16'(extVerifyAllow), 16'(pairs[m] != 2'b00));
        end
        lockOp(1'b0, 8'hff);
        check("lockNoSet", 16'(flash_lock_byte), 16'h00fc);
        lockOp(1'b1, 8'h00);
        check("lockErase", 16'(flash_lock_byte), 16'h00ff);
        endOfTest();
    end

    // watchdog
    initial
    begin
        #100000;
        fails++;
        endOfTest();
    end
endmodule
